// *** src/psw_consts.svh ***
// offsets, field positions, reset values and timing for the power state sequencer
`ifndef PSW_CONSTS_SVH
`define PSW_CONSTS_SVH

`define PSW_CLK_NS        5
`define PSW_TICK_US       1000
`define PSW_SHORT_MS      13'h0FA0
`define PSW_LONG_MS       13'h1770
`define PSW_SYNC_IDLE     8'hD0

`define PSW_OFF_CTRL      8'h00
`define PSW_OFF_CMD       8'h04
`define PSW_OFF_STAT      8'h08
`define PSW_OFF_ISTAT     8'h0C
`define PSW_OFF_IMASK     8'h10

`define PSW_CTRL_W        7
`define PSW_CTRL_RST      7'h00
`define PSW_CTRL_POL      1:0
`define PSW_CTRL_USB45    2
`define PSW_CTRL_DEEP     3
`define PSW_CTRL_RTC      4
`define PSW_CTRL_DUAL     5
`define PSW_CTRL_REARM    6

`define PSW_CMD_TGT       1:0

`define PSW_INT_W         4
`define PSW_INT_BTN       0
`define PSW_INT_WAKE      1
`define PSW_INT_FORCE     2
`define PSW_INT_AC        3

`define PSW_RESP_OKAY     2'h0
`define PSW_RESP_SLVERR   2'h2

`endif

// *** src/psw_pkg.sv ***
// types shared by the power state and wake sequencer
package psw_pkg;

    typedef enum logic [2:0] {
        PSW_ST_OFF  = 3'b000,
        PSW_ST_WORK = 3'b001,
        PSW_ST_S3   = 3'b010,
        PSW_ST_S4   = 3'b011,
        PSW_ST_G3   = 3'b100
    } psw_state_t;

    typedef enum logic [1:0] {
        PSW_RK_COLD = 2'b00,
        PSW_RK_RAM  = 2'b01,
        PSW_RK_DISK = 2'b10
    } psw_resume_t;

    typedef enum logic [1:0] {
        PSW_POL_OFF  = 2'b00,
        PSW_POL_ON   = 2'b01,
        PSW_POL_LAST = 2'b10
    } psw_policy_t;

    typedef enum logic [1:0] {
        PSW_CMD_NONE = 2'b00,
        PSW_CMD_S3   = 2'b01,
        PSW_CMD_S4   = 2'b10,
        PSW_CMD_S5   = 2'b11
    } psw_cmd_t;

    typedef enum logic [2:0] {
        PSW_R_CTRL  = 3'b000,
        PSW_R_CMD   = 3'b001,
        PSW_R_STAT  = 3'b010,
        PSW_R_ISTAT = 3'b011,
        PSW_R_IMASK = 3'b100,
        PSW_R_NONE  = 3'b111
    } psw_reg_t;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic [2:0]  awprot;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic [2:0]  arprot;
        logic        rready;
    } psw_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } psw_axi_rsp_t;

    // pin order: 0 switch, 1 alarm, 2 net, 3 usb, 4 pcie_wake_n, 5 ir, 6 ac, 7 standby
    typedef struct packed {
        logic [7:0]  sync1;
        logic [7:0]  sync2;
        psw_state_t  st;
        logic        last_on;
        logic        armed;
        logic        disp_on;
        psw_resume_t kind;
        logic [23:0] tick_cnt;
        logic [12:0] ms_cnt;
        logic        long_done;
        logic        psw_prev;
        logic [6:0]  ctrl;
        logic [3:0]  istat;
        logic [3:0]  imask;
        logic        aw_held;
        logic [31:0] awaddr;
        logic        w_held;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        main_en;
        logic        ram_en;
        logic        led_pwr;
        logic        led_amber;
        logic        disp_en;
        logic        stby_led;
        logic        irq;
    } psw_regs_t;

    localparam psw_regs_t PSW_REGS_RST = '0;

endpackage : psw_pkg

// *** src/psw_sequencer.sv ***
// power state and wake sequencer with AXI4-Lite register slave
// Notes on behaviour
// - short press powers on, wakes, or requests sleep
// - hold over six seconds forces soft-off
// - suspend-to-RAM keeps memory and wake logic powered
// - wake from S3 resumes, no cold boot
// - S3 shows amber, single colour indicator off
// - power switch wakes from S3, S4, S5
// - enabled clock alarm wakes from S3, S4, S5
// - network wake request powers system up
// - usb wakes; S4/S5 gated by enable
// - asserted pcie wake line wakes the system
// - infrared receiver activity wakes the system
// - radio activity never wakes the system
// - usb/infrared deep wake only without deep standby
// - usb/infrared ignored after AC return until rearmed
// - alarm/net/pcie wake from S3 keeps display asleep
// - AC return follows off/on/last-state policy
// - S5 exit is cold boot, S4 disk resume
// - standby indicator follows standby rail presence
`include "psw_consts.svh"

module psw_sequencer #(
    parameter int unsigned MS_TICK_CYC = (`PSW_TICK_US * 1000) / `PSW_CLK_NS
) (
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    input  wire psw_pkg::psw_axi_req_t axi_req,
    output psw_pkg::psw_axi_rsp_t     axi_rsp,
    input  wire logic                 power_switch,
    input  wire logic                 rtc_alarm,
    input  wire logic                 network_wake_request,
    input  wire logic                 usb_activity,
    input  wire logic                 pcie_wake_n,
    input  wire logic                 infrared_remote_receiver,
    input  wire logic                 ac_power_good,
    input  wire logic                 standby_rail_present,
    output logic                      main_rail_en,
    output logic                      ram_rail_en,
    output logic                      led_power,
    output logic                      led_amber,
    output logic                      display_en,
    output logic                      standby_led,
    output psw_pkg::psw_resume_t      resume_kind,
    output logic                      irq
);
    import psw_pkg::*;

    // all state in one struct, next value built in one place
    psw_regs_t r_q;
    psw_regs_t r_d;

    function automatic psw_reg_t dec(input logic [31:0] a);
        psw_reg_t idx;
        idx = PSW_R_NONE;
        if (a[31:8] == 24'h000000)
        begin
            case (a[7:0])
                `PSW_OFF_CTRL:  idx = PSW_R_CTRL;
                `PSW_OFF_CMD:   idx = PSW_R_CMD;
                `PSW_OFF_STAT:  idx = PSW_R_STAT;
                `PSW_OFF_ISTAT: idx = PSW_R_ISTAT;
                `PSW_OFF_IMASK: idx = PSW_R_IMASK;
                default:        idx = PSW_R_NONE;
            endcase
        end
        return idx;
    endfunction : dec

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    logic          s_psw;
    logic          s_rtc;
    logic          s_net;
    logic          s_usb;
    logic          s_pwn;
    logic          s_ir;
    logic          s_acg;
    logic          s_stby;
    logic          tick;
    logic          short_ev;
    logic          long_ev;
    logic          usb_ok;
    logic          ir_ok;
    logic          quiet_wake;
    logic          loud_wake;
    logic          cmd_v;
    psw_cmd_t      cmd_tgt;
    psw_reg_t      widx;
    psw_reg_t      ridx;
    logic [31:0]   wval;
    logic [31:0]   stat_word;

    assign axi_rsp.awready = !r_q.aw_held && !r_q.bvalid;
    assign axi_rsp.wready  = !r_q.w_held && !r_q.bvalid;
    assign axi_rsp.bvalid  = r_q.bvalid;
    assign axi_rsp.bresp   = r_q.bresp;
    assign axi_rsp.arready = !r_q.rvalid;
    assign axi_rsp.rvalid  = r_q.rvalid;
    assign axi_rsp.rdata   = r_q.rdata;
    assign axi_rsp.rresp   = r_q.rresp;

    assign main_rail_en = r_q.main_en;
    assign ram_rail_en  = r_q.ram_en;
    assign led_power    = r_q.led_pwr;
    assign led_amber    = r_q.led_amber;
    assign display_en   = r_q.disp_en;
    assign standby_led  = r_q.stby_led;
    assign resume_kind  = r_q.kind;
    assign irq          = r_q.irq;

    always_comb
    begin
        r_d = r_q;
        cmd_v = 1'b0;
        cmd_tgt = PSW_CMD_NONE;
        wval = 32'h00000000;

        // only the second stage is read by logic
        r_d.sync1 = {standby_rail_present, ac_power_good, infrared_remote_receiver, pcie_wake_n,
                     usb_activity, network_wake_request, rtc_alarm, power_switch};
        r_d.sync2 = r_q.sync1;
        s_psw  = r_q.sync2[0];
        s_rtc  = r_q.sync2[1];
        s_net  = r_q.sync2[2];
        s_usb  = r_q.sync2[3];
        s_pwn  = r_q.sync2[4];
        s_ir   = r_q.sync2[5];
        s_acg  = r_q.sync2[6];
        s_stby = r_q.sync2[7];

        // millisecond tick so the second-scale hold times fit small counters
        tick = (r_q.tick_cnt == 24'(MS_TICK_CYC - 1));
        r_d.tick_cnt = tick ? 24'h000000 : r_q.tick_cnt + 24'h000001;

        // press duration runs from press to release or the long limit
        r_d.psw_prev = s_psw;
        long_ev = 1'b0;
        if (s_psw)
        begin
            if (tick && !r_q.long_done)
            begin
                r_d.ms_cnt = r_q.ms_cnt + 13'h0001;
                if (r_q.ms_cnt == `PSW_LONG_MS - 13'h0001)
                begin
                    long_ev = 1'b1;
                    r_d.long_done = 1'b1;
                end
            end
        end
        else
        begin
            r_d.ms_cnt = 13'h0000;
            r_d.long_done = 1'b0;
        end
        short_ev = r_q.psw_prev && !s_psw && !r_q.long_done;

        // register writes: address and data may arrive in either order
        if (axi_req.awvalid && axi_rsp.awready)
        begin
            r_d.aw_held = 1'b1;
            r_d.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready)
        begin
            r_d.w_held = 1'b1;
            r_d.wdata = axi_req.wdata;
            r_d.wstrb = axi_req.wstrb;
        end
        widx = dec(r_q.awaddr);
        if (r_q.aw_held && r_q.w_held)
        begin
            r_d.aw_held = 1'b0;
            r_d.w_held = 1'b0;
            r_d.bvalid = 1'b1;
            r_d.bresp = `PSW_RESP_OKAY;
            case (widx)
                PSW_R_CTRL:
                begin
                    wval = merge({25'h0000000, r_q.ctrl}, r_q.wdata, r_q.wstrb);
                    r_d.ctrl = wval[`PSW_CTRL_W-1:0];
                    r_d.ctrl[`PSW_CTRL_REARM] = 1'b0;
                    if (wval[`PSW_CTRL_REARM])
                    begin
                        r_d.armed = 1'b1;
                    end
                end
                PSW_R_CMD:
                begin
                    wval = merge(32'h00000000, r_q.wdata, r_q.wstrb);
                    cmd_tgt = psw_cmd_t'(wval[`PSW_CMD_TGT]);
                    // only acted on while working
                    cmd_v = (cmd_tgt != PSW_CMD_NONE);
                end
                PSW_R_ISTAT:
                begin
                    wval = merge(32'h00000000, r_q.wdata, r_q.wstrb);
                    // later sets win over this clear
                    r_d.istat = r_q.istat & ~wval[`PSW_INT_W-1:0];
                end
                PSW_R_IMASK:
                begin
                    wval = merge({28'h0000000, r_q.imask}, r_q.wdata, r_q.wstrb);
                    r_d.imask = wval[`PSW_INT_W-1:0];
                end
                PSW_R_STAT:
                begin
                    r_d.bresp = `PSW_RESP_OKAY;
                end
                default:
                begin
                    r_d.bresp = `PSW_RESP_SLVERR;
                end
            endcase
        end
        if (r_q.bvalid && axi_req.bready)
        begin
            r_d.bvalid = 1'b0;
        end

        // usb and infrared: deep states need the enables and rearmed logic
        usb_ok = r_q.armed && ((r_q.st == PSW_ST_S3) ||
                 (r_q.ctrl[`PSW_CTRL_USB45] && !r_q.ctrl[`PSW_CTRL_DEEP]));
        ir_ok  = r_q.armed && ((r_q.st == PSW_ST_S3) || !r_q.ctrl[`PSW_CTRL_DEEP]);
        // no radio input exists, so it can never take part here
        quiet_wake = (s_rtc && r_q.ctrl[`PSW_CTRL_RTC]) || s_net || !s_pwn;
        loud_wake  = short_ev || (s_usb && usb_ok) || (s_ir && ir_ok);

        // ac loss overrides every state and command
        if (!s_acg && (r_q.st != PSW_ST_G3))
        begin
            r_d.last_on = (r_q.st == PSW_ST_WORK);
            r_d.st = PSW_ST_G3;
        end
        else
        begin
            case (r_q.st)
                PSW_ST_G3:
                begin
                    if (s_acg)
                    begin
                        r_d.istat[`PSW_INT_AC] = 1'b1;
                        r_d.armed = 1'b0;
                        r_d.kind = PSW_RK_COLD;
                        r_d.disp_on = 1'b1;
                        case (psw_policy_t'(r_q.ctrl[`PSW_CTRL_POL]))
                            PSW_POL_ON:   r_d.st = PSW_ST_WORK;
                            PSW_POL_LAST: r_d.st = r_q.last_on ? PSW_ST_WORK : PSW_ST_OFF;
                            default:      r_d.st = PSW_ST_OFF;
                        endcase
                    end
                end
                PSW_ST_WORK:
                begin
                    // working rearms usb and infrared wake
                    r_d.armed = 1'b1;
                    if (long_ev)
                    begin
                        r_d.st = PSW_ST_OFF;
                        r_d.istat[`PSW_INT_FORCE] = 1'b1;
                    end
                    else if (cmd_v)
                    begin
                        // software decides sleep depth after a short press
                        case (cmd_tgt)
                            PSW_CMD_S3: r_d.st = PSW_ST_S3;
                            PSW_CMD_S4: r_d.st = PSW_ST_S4;
                            default:    r_d.st = PSW_ST_OFF;
                        endcase
                    end
                    if (short_ev)
                    begin
                        r_d.istat[`PSW_INT_BTN] = 1'b1;
                    end
                end
                PSW_ST_S3,
                PSW_ST_S4,
                PSW_ST_OFF:
                begin
                    // nothing to force from soft-off
                    if (long_ev && (r_q.st != PSW_ST_OFF))
                    begin
                        r_d.st = PSW_ST_OFF;
                        r_d.istat[`PSW_INT_FORCE] = 1'b1;
                    end
                    else if (quiet_wake || loud_wake)
                    begin
                        r_d.st = PSW_ST_WORK;
                        r_d.istat[`PSW_INT_WAKE] = 1'b1;
                        case (r_q.st)
                            PSW_ST_S3: r_d.kind = PSW_RK_RAM;
                            PSW_ST_S4: r_d.kind = PSW_RK_DISK;
                            default:   r_d.kind = PSW_RK_COLD;
                        endcase
                        r_d.disp_on = !((r_q.st == PSW_ST_S3) && !loud_wake);
                    end
                end
                default:
                begin
                    r_d.st = PSW_ST_OFF;
                end
            endcase
        end

        // reads answer one cycle after the address is taken
        ridx = dec(axi_req.araddr);
        // bit 7 warns of a coming forced off
        stat_word = {23'h000000, s_stby, (r_q.ms_cnt >= `PSW_SHORT_MS), r_q.disp_on, r_q.armed,
                     r_q.kind, r_q.st};
        if (axi_req.arvalid && axi_rsp.arready)
        begin
            r_d.rvalid = 1'b1;
            r_d.rresp = `PSW_RESP_OKAY;
            case (ridx)
                PSW_R_CTRL:  r_d.rdata = {25'h0000000, r_q.ctrl};
                PSW_R_CMD:   r_d.rdata = 32'h00000000;
                PSW_R_STAT:  r_d.rdata = stat_word;
                PSW_R_ISTAT: r_d.rdata = {28'h0000000, r_q.istat};
                PSW_R_IMASK: r_d.rdata = {28'h0000000, r_q.imask};
                default:
                begin
                    r_d.rdata = 32'h00000000;
                    r_d.rresp = `PSW_RESP_SLVERR;
                end
            endcase
        end
        else if (r_q.rvalid && axi_req.rready)
        begin
            r_d.rvalid = 1'b0;
        end

        // outputs follow the next state so they line up with it
        r_d.main_en   = (r_d.st == PSW_ST_WORK);
        r_d.ram_en    = (r_d.st == PSW_ST_WORK) || (r_d.st == PSW_ST_S3);
        r_d.led_pwr   = (r_d.st == PSW_ST_WORK);
        r_d.led_amber = (r_d.st == PSW_ST_S3) && r_d.ctrl[`PSW_CTRL_DUAL];
        r_d.disp_en   = (r_d.st == PSW_ST_WORK) && r_d.disp_on;
        r_d.stby_led  = s_stby;
        // level irq: unmasking a pending bit raises it
        r_d.irq       = |(r_d.istat & r_d.imask);
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            r_q <= PSW_REGS_RST;
            // idle pin levels, so reset fakes no ac loss or wake
            r_q.sync1 <= `PSW_SYNC_IDLE;
            r_q.sync2 <= `PSW_SYNC_IDLE;
        end
        else
        begin
            r_q <= r_d;
        end
    end

endmodule : psw_sequencer

// *** verification/psw_sequencer_monitor.sv ***
// concurrent checks on the power state sequencer ports
module psw_sequencer_monitor #(
    parameter int unsigned MS_TICK_CYC = 4
) (
    input wire logic                 sys_clk,
    input wire logic                 sys_rst,
    input wire logic                 power_switch,
    input wire logic                 network_wake_request,
    input wire logic                 usb_activity,
    input wire logic                 pcie_wake_n,
    input wire logic                 infrared_remote_receiver,
    input wire logic                 standby_rail_present,
    input wire logic                 main_rail_en,
    input wire logic                 ram_rail_en,
    input wire logic                 led_power,
    input wire logic                 led_amber,
    input wire logic                 display_en,
    input wire logic                 standby_led,
    input wire psw_pkg::psw_resume_t resume_kind
);
    timeunit 1ns;
    timeprecision 1ps;
    import psw_pkg::*;

    // slack covers tick phase and the input synchroniser
    localparam int unsigned LONG_CYC  = 6001 * MS_TICK_CYC + 8;
    localparam int unsigned SHORT_MAX = 5900 * MS_TICK_CYC;

    logic [15:0] hold_q;
    logic        s3;

    assign s3 = ram_rail_en && !main_rail_en;

    always_ff @(posedge sys_clk)
    begin
        hold_q <= (sys_rst || !power_switch) ? 16'h0000 : hold_q + 16'h0001;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_amber_s3;
        led_amber |-> s3 && !led_power;
    endproperty
    a_amber_s3 : assert property (p_amber_s3) else $error("amber lit outside suspend");

    property p_ram_kept;
        main_rail_en |-> ram_rail_en;
    endproperty
    a_ram_kept : assert property (p_ram_kept) else $error("memory rail off while working");

    property p_standby_led;
        standby_rail_present [*5] |-> standby_led;
    endproperty
    a_standby_led : assert property (p_standby_led) else $error("standby indicator dark");

    property p_s3_resume;
        s3 && $rose(network_wake_request) |-> ##[1:4] (main_rail_en && resume_kind == PSW_RK_RAM);
    endproperty
    a_s3_resume : assert property (p_s3_resume) else $error("no memory resume from suspend");

    property p_cold_entry;
        $rose(ram_rail_en) |-> resume_kind != PSW_RK_RAM;
    endproperty
    a_cold_entry : assert property (p_cold_entry) else $error("memory resume without saved memory");

    property p_quiet_wake;
        s3 && $fell(pcie_wake_n) && !usb_activity && !infrared_remote_receiver && !power_switch
            |-> ##[1:4] (main_rail_en && !display_en);
    endproperty
    a_quiet_wake : assert property (p_quiet_wake) else $error("display woken by quiet source");

    property p_long_off;
        hold_q == LONG_CYC[15:0] |-> !ram_rail_en;
    endproperty
    a_long_off : assert property (p_long_off) else $error("long hold did not force off");

    property p_short_on;
        $fell(power_switch) && !ram_rail_en && hold_q > 16'h0008 && hold_q < SHORT_MAX[15:0]
            |-> ##[1:6] main_rail_en;
    endproperty
    a_short_on : assert property (p_short_on) else $error("short press did not power on");
endmodule : psw_sequencer_monitor

bind psw_sequencer psw_sequencer_monitor #(.MS_TICK_CYC(MS_TICK_CYC)) u_psw_sequencer_monitor (
    .sys_clk                  (sys_clk),
    .sys_rst                  (sys_rst),
    .power_switch             (power_switch),
    .network_wake_request     (network_wake_request),
    .usb_activity             (usb_activity),
    .pcie_wake_n              (pcie_wake_n),
    .infrared_remote_receiver (infrared_remote_receiver),
    .standby_rail_present     (standby_rail_present),
    .main_rail_en             (main_rail_en),
    .ram_rail_en              (ram_rail_en),
    .led_power                (led_power),
    .led_amber                (led_amber),
    .display_en               (display_en),
    .standby_led              (standby_led),
    .resume_kind              (resume_kind)
);

// *** verification/psw_wake_model.sv ***
// power switch, wake sources and supply pins facing the sequencer
module psw_wake_model (
    input  wire logic       sys_clk,
    output logic [7:0]      pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // order: switch, alarm, net, usb, pcie wake (low active), ir, ac good, standby
    localparam logic [7:0] IDLE = 8'hD0;

    initial pins = IDLE;

    // holds one source away from idle for n cycles
    task automatic act(input int i, input int n);
        @(posedge sys_clk);
        pins[i] <= ~IDLE[i];
        repeat (n) @(posedge sys_clk);
        pins[i] <= IDLE[i];
    endtask : act
endmodule : psw_wake_model

// *** verification/psw_sequencer_bench.sv ***
// self-checking bench for the power state sequencer
`include "psw_consts.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end

module psw_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import psw_pkg::*;

    localparam int MS = 4;

    logic         sys_clk = 1'b0;
    logic         sys_rst = 1'b1;
    psw_axi_req_t rq      = '0;
    psw_axi_rsp_t rs;
    logic [7:0]   pins;
    logic         main_rail_en, ram_rail_en, led_power, led_amber, display_en, standby_led, irq;
    psw_resume_t  resume_kind;
    int           mismatches   = 0;
    int           total_checks = 0;
    int           cyc          = 0;

    always #2.5 sys_clk = ~sys_clk;

    psw_wake_model u_psw_wake_model (.sys_clk(sys_clk), .pins(pins));

    psw_sequencer #(.MS_TICK_CYC(MS)) u_psw_sequencer (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .axi_req(rq), .axi_rsp(rs),
        .power_switch(pins[0]), .rtc_alarm(pins[1]), .network_wake_request(pins[2]),
        .usb_activity(pins[3]), .pcie_wake_n(pins[4]), .infrared_remote_receiver(pins[5]),
        .ac_power_good(pins[6]), .standby_rail_present(pins[7]),
        .main_rail_en(main_rail_en), .ram_rail_en(ram_rail_en), .led_power(led_power),
        .led_amber(led_amber), .display_en(display_en), .standby_led(standby_led),
        .resume_kind(resume_kind), .irq(irq)
    );

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        rq.awvalid <= 1'b1;
        rq.awaddr  <= a;
        rq.wvalid  <= 1'b1;
        rq.wdata   <= d;
        rq.wstrb   <= 4'hF;
        rq.bready  <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
        end
        while (!rs.bvalid);
        rq.bready <= 1'b0;
        `CHK(rs.bresp, er)
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge sys_clk);
        rq.arvalid <= 1'b1;
        rq.araddr  <= a;
        rq.rready  <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (rs.arready) rq.arvalid <= 1'b0;
        end
        while (!rs.rvalid);
        rq.rready <= 1'b0;
        `CHK(rs.rdata, ed)
        `CHK(rs.rresp, er)
    endtask : rd

    // waits a bounded time for the working state
    task automatic till(input int n);
        int k;
        k = 0;
        while (main_rail_en !== 1'b1 && k < n)
        begin
            @(posedge sys_clk);
            k++;
        end
        `CHK(main_rail_en, 1'b1)
    endtask : till

    task automatic quiet(input int n);
        repeat (n) @(posedge sys_clk);
        `CHK(main_rail_en, 1'b0)
    endtask : quiet

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd(`PSW_OFF_CTRL, 32'h0, `PSW_RESP_OKAY);
        rd(`PSW_OFF_STAT, 32'h100, `PSW_RESP_OKAY);
        rd(32'h20, 32'h0, `PSW_RESP_SLVERR);
        wr(32'h20, 32'h1, `PSW_RESP_SLVERR);
        wr(`PSW_OFF_STAT, 32'hFF, `PSW_RESP_OKAY);
        u_psw_wake_model.act(0, 40);
        till(20);
        `CHK(led_power, 1'b1)
        `CHK(resume_kind, PSW_RK_COLD)
        rd(`PSW_OFF_STAT, 32'h161, `PSW_RESP_OKAY);
        wr(`PSW_OFF_ISTAT, 32'hF, `PSW_RESP_OKAY);
        wr(`PSW_OFF_IMASK, 32'hF, `PSW_RESP_OKAY);
        u_psw_wake_model.act(0, 40);
        repeat (10) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        `CHK(main_rail_en, 1'b1)
        wr(`PSW_OFF_IMASK, 32'h0, `PSW_RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        rd(`PSW_OFF_ISTAT, 32'h1, `PSW_RESP_OKAY);
        wr(`PSW_OFF_ISTAT, 32'h1, `PSW_RESP_OKAY);
        rd(`PSW_OFF_ISTAT, 32'h0, `PSW_RESP_OKAY);
        wr(`PSW_OFF_CTRL, 32'h30, `PSW_RESP_OKAY);
        // alarm, net, usb, pcie, ir from suspend to memory; only usb and ir light the display
        for (int i = 1; i <= 5; i++)
        begin
            wr(`PSW_OFF_CMD, 32'h1, `PSW_RESP_OKAY);
            quiet(4);
            `CHK(ram_rail_en, 1'b1)
            `CHK(led_amber, 1'b1)
            `CHK(led_power, 1'b0)
            u_psw_wake_model.act(i, 8);
            till(20);
            `CHK(resume_kind, PSW_RK_RAM)
            `CHK(display_en, (i == 3 || i == 5))
        end
        wr(`PSW_OFF_CMD, 32'h2, `PSW_RESP_OKAY);
        u_psw_wake_model.act(3, 8);
        quiet(10);
        wr(`PSW_OFF_CTRL, 32'h3C, `PSW_RESP_OKAY);
        u_psw_wake_model.act(5, 8);
        quiet(10);
        u_psw_wake_model.act(3, 8);
        quiet(10);
        wr(`PSW_OFF_CTRL, 32'h34, `PSW_RESP_OKAY);
        u_psw_wake_model.act(5, 8);
        till(20);
        `CHK(resume_kind, PSW_RK_DISK)
        wr(`PSW_OFF_CMD, 32'h3, `PSW_RESP_OKAY);
        u_psw_wake_model.act(1, 8);
        till(20);
        `CHK(resume_kind, PSW_RK_COLD)
        wr(`PSW_OFF_ISTAT, 32'hF, `PSW_RESP_OKAY);
        u_psw_wake_model.act(0, 5000 * MS);
        repeat (10) @(posedge sys_clk);
        `CHK(main_rail_en, 1'b1)
        rd(`PSW_OFF_ISTAT, 32'h1, `PSW_RESP_OKAY);
        wr(`PSW_OFF_ISTAT, 32'hF, `PSW_RESP_OKAY);
        u_psw_wake_model.act(0, 6000 * MS + 20);
        quiet(10);
        `CHK(ram_rail_en, 1'b0)
        rd(`PSW_OFF_ISTAT, 32'h4, `PSW_RESP_OKAY);
        wr(`PSW_OFF_CTRL, 32'h05, `PSW_RESP_OKAY);
        u_psw_wake_model.act(6, 20);
        till(40);
        wr(`PSW_OFF_CTRL, 32'h04, `PSW_RESP_OKAY);
        u_psw_wake_model.act(6, 20);
        quiet(10);
        u_psw_wake_model.act(3, 8);
        quiet(10);
        wr(`PSW_OFF_CTRL, 32'h44, `PSW_RESP_OKAY);
        u_psw_wake_model.act(3, 8);
        till(20);
        wr(`PSW_OFF_CMD, 32'h1, `PSW_RESP_OKAY);
        quiet(4);
        `CHK(led_amber, 1'b0)
        fork
            u_psw_wake_model.act(7, 10);
            begin
                repeat (8) @(posedge sys_clk);
                `CHK(standby_led, 1'b0)
            end
        join
        repeat (6) @(posedge sys_clk);
        `CHK(standby_led, 1'b1)
        report_and_stop();
    end
endmodule : psw_sequencer_bench
